//--- hw/coex_signalling.sv
// Purpose: three-wire coexistence signalling towards two external radios
// Assumes: register port strobes are one cycle, never overlapping
// Notes:   outputs lag the envelope by one register stage
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module coex_signalling (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        ext_activity_in0,
  input  wire logic        ext_activity_in1,
  input  wire logic        event_envelope_in,
  input  wire logic        activity_done_in,
  output logic             local_radio_active_out,
  output logic             local_priority_out,
  output logic             radio_inhibit_out
);
  // ==========================================================================
  // registers
  logic        act_gating_select_r;
  logic        priority_owner_select_r;
  logic [5:0]  pin_act0_r;
  logic [5:0]  pin_act1_r;
  logic [5:0]  pin_acto_r;
  logic [5:0]  pin_prio_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        act_r;
  logic        act_nxt;
  logic        pri_r;
  logic        pri_nxt;
  logic        inh_r;
  logic        inh_nxt;
  logic        ext0_s;
  logic        ext1_s;
  logic        busy;
  logic        ext_any;
  logic        local_wins;
  logic        wr_ctrl;
  logic        wr_prio;
  logic        wr_pins;
  logic        in0_en;
  logic        in1_en;
  logic        acto_ok;
  logic        prio_ok;
  logic        ext_wins;
  logic        rd_ctrl;
  logic        rd_prio;
  logic        rd_status;
  logic        rd_pins;
  logic [coex_pkg::STATUS_W-1:0] status_bits;

  // ==========================================================================
  // decode helpers: one compare shared by the port, the outputs and the checks
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit
  function automatic logic code_hit(input logic [coex_pkg::PINSEL_W-1:0] code,
                                    input logic [coex_pkg::PINSEL_W-1:0] target);
    code_hit = (code == target);
  endfunction : code_hit

  // ==========================================================================
  // input synchronisers and envelope stretcher
  coex_sync #(.STAGES(coex_pkg::SYNC_STAGES)) u_sync0 (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (ext_activity_in0),
    .q_out  (ext0_s)
  );
  coex_sync #(.STAGES(coex_pkg::SYNC_STAGES)) u_sync1 (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (ext_activity_in1),
    .q_out  (ext1_s)
  );
  coex_envelope u_env (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .event_envelope_in (event_envelope_in),
    .activity_done_in  (activity_done_in),
    .busy_out          (busy)
  );

  // ==========================================================================
  // input routing: an input counts only if its pin carries the right code
  assign in0_en  = code_hit(pin_act0_r, coex_pkg::FUNC_EXT_REQ0);
  assign in1_en  = code_hit(pin_act1_r, coex_pkg::FUNC_EXT_REQ1);
  assign acto_ok = code_hit(pin_acto_r, coex_pkg::FUNC_ACT_OUT);
  assign prio_ok = code_hit(pin_prio_r, coex_pkg::FUNC_PRIO_OUT);
  // both radios merge into one request at one shared level
  assign ext_any = (ext0_s & in0_en) | (ext1_s & in1_en);
  assign local_wins = (priority_owner_select_r == coex_pkg::OWNER_LOCAL);
  // external precedence with a live request: the local radio must back off
  assign ext_wins   = ~local_wins & ext_any;

  // ==========================================================================
  // output logic
  always_comb begin
    act_nxt = 1'b0;
    if (!act_gating_select_r) begin
      act_nxt = busy;
      if (ext_wins) begin
        act_nxt = 1'b0;
      end
    end else begin
      act_nxt = busy & local_wins;
    end
    if (local_wins) begin
      pri_nxt = act_nxt;
    end else begin
      pri_nxt = 1'b0;
    end
    inh_nxt = ext_wins;
  end
  // activity and priority outputs only drive when routed to a pin with the matching code; inhibit is not gated
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_r <= 1'b0;
      pri_r <= 1'b0;
      inh_r <= 1'b0;
    end else begin
      act_r <= act_nxt & acto_ok;
      pri_r <= pri_nxt & prio_ok;
      inh_r <= inh_nxt;
    end
  end
  assign local_radio_active_out = act_r;
  assign local_priority_out     = pri_r;
  assign radio_inhibit_out      = inh_r;

  // ==========================================================================
  // register port; power and clock must be up before these are written
  assign wr_ctrl   = wr_in & addr_hit(addr_in, coex_pkg::CTRL_ADDR);
  assign wr_prio   = wr_in & addr_hit(addr_in, coex_pkg::PRIO_ADDR);
  assign wr_pins   = wr_in & addr_hit(addr_in, coex_pkg::PINSEL_ADDR);
  // read selects ignore rd_in: the strobe only gates the capture flop
  assign rd_ctrl   = addr_hit(addr_in, coex_pkg::CTRL_ADDR);
  assign rd_prio   = addr_hit(addr_in, coex_pkg::PRIO_ADDR);
  assign rd_status = addr_hit(addr_in, coex_pkg::STATUS_ADDR);
  assign rd_pins   = addr_hit(addr_in, coex_pkg::PINSEL_ADDR);
  assign status_bits = {inh_r, pri_r, act_r, ext1_s, ext0_s};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_gating_select_r     <= coex_pkg::CTRL_GATING_RST;
      priority_owner_select_r <= coex_pkg::PRIO_OWNER_RST;
      pin_act0_r              <= '0;
      pin_act1_r              <= '0;
      pin_acto_r              <= '0;
      pin_prio_r              <= '0;
    end else begin
      if (wr_ctrl) begin
        act_gating_select_r <= wdata_in[coex_pkg::CTRL_GATING_BIT];
      end
      if (wr_prio) begin
        priority_owner_select_r <= wdata_in[coex_pkg::PRIO_OWNER_BIT];
      end
      if (wr_pins) begin
        pin_act0_r <= wdata_in[coex_pkg::PINSEL_ACT0_LSB +: coex_pkg::PINSEL_W];
        pin_act1_r <= wdata_in[coex_pkg::PINSEL_ACT1_LSB +: coex_pkg::PINSEL_W];
        pin_acto_r <= wdata_in[coex_pkg::PINSEL_ACTO_LSB +: coex_pkg::PINSEL_W];
        pin_prio_r <= wdata_in[coex_pkg::PINSEL_PRIO_LSB +: coex_pkg::PINSEL_W];
      end
    end
  end
  // unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (rd_ctrl) begin
      rdata_nxt[coex_pkg::CTRL_GATING_BIT] = act_gating_select_r;
    end else if (rd_prio) begin
      rdata_nxt[coex_pkg::PRIO_OWNER_BIT] = priority_owner_select_r;
    end else if (rd_status) begin
      rdata_nxt[coex_pkg::STATUS_W-1:0] = status_bits;
    end else if (rd_pins) begin
      rdata_nxt[coex_pkg::PINSEL_ACT0_LSB +: coex_pkg::PINSEL_W] = pin_act0_r;
      rdata_nxt[coex_pkg::PINSEL_ACT1_LSB +: coex_pkg::PINSEL_W] = pin_act1_r;
      rdata_nxt[coex_pkg::PINSEL_ACTO_LSB +: coex_pkg::PINSEL_W] = pin_acto_r;
      rdata_nxt[coex_pkg::PINSEL_PRIO_LSB +: coex_pkg::PINSEL_W] = pin_prio_r;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_in ? rdata_nxt : '0;
    end
  end
  assign rdata_out = rdata_r;

  // ==========================================================================
  // checks
  property p_ungated_follow;
    @(posedge clk_in) disable iff (rst_in)
    (!act_gating_select_r && local_wins && pin_acto_r == coex_pkg::FUNC_ACT_OUT
     && event_envelope_in) |=> local_radio_active_out;
  endproperty
  a_ungated_follow: assert property (p_ungated_follow)
    else $error("activity output missed envelope");

  property p_pri_copy;
    @(posedge clk_in) disable iff (rst_in)
    ($past(local_wins) && $past(pin_prio_r) == coex_pkg::FUNC_PRIO_OUT &&
     $past(pin_acto_r) == coex_pkg::FUNC_ACT_OUT)
      |-> local_priority_out == local_radio_active_out;
  endproperty
  a_pri_copy: assert property (p_pri_copy)
    else $error("priority output does not copy activity");

  property p_ext_pri_low;
    @(posedge clk_in) disable iff (rst_in)
    (!local_wins && ext_any) |=> !local_priority_out && !local_radio_active_out;
  endproperty
  a_ext_pri_low: assert property (p_ext_pri_low)
    else $error("outputs high during external activity");

  property p_gated_ext;
    @(posedge clk_in) disable iff (rst_in)
    (act_gating_select_r && !local_wins) |=> !local_radio_active_out;
  endproperty
  a_gated_ext: assert property (p_gated_ext)
    else $error("gated activity without local precedence");

  property p_inhibit;
    @(posedge clk_in) disable iff (rst_in)
    (!local_wins && ext_any) |=> radio_inhibit_out;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("local radio not inhibited");

  property p_inhibit_clear;
    @(posedge clk_in) disable iff (rst_in)
    !ext_wins |=> !radio_inhibit_out;
  endproperty
  a_inhibit_clear: assert property (p_inhibit_clear)
    else $error("local radio inhibited without external request");

  property p_ungated_busy;
    @(posedge clk_in) disable iff (rst_in)
    (!act_gating_select_r && local_wins && acto_ok && busy) |=> local_radio_active_out;
  endproperty
  a_ungated_busy: assert property (p_ungated_busy)
    else $error("ungated activity output missed local activity");

  property p_hold_stretch;
    @(posedge clk_in) disable iff (rst_in)
    (!act_gating_select_r && local_wins && acto_ok && busy && !event_envelope_in)
      |=> local_radio_active_out;
  endproperty
  a_hold_stretch: assert property (p_hold_stretch)
    else $error("activity output dropped before completion");

  property p_act_fall;
    @(posedge clk_in) disable iff (rst_in)
    ($fell(local_radio_active_out) && !$past(act_gating_select_r) && $past(local_wins)
     && $past(acto_ok)) |-> !$past(event_envelope_in);
  endproperty
  a_act_fall: assert property (p_act_fall)
    else $error("activity output fell with envelope still high");

  property p_gated_together;
    @(posedge clk_in) disable iff (rst_in)
    (act_gating_select_r && local_wins && acto_ok && prio_ok && event_envelope_in)
      |=> (local_radio_active_out && local_priority_out);
  endproperty
  a_gated_together: assert property (p_gated_together)
    else $error("gated outputs did not rise together");

  property p_ext_pri_zero;
    @(posedge clk_in) disable iff (rst_in)
    !local_wins |=> !local_priority_out;
  endproperty
  a_ext_pri_zero: assert property (p_ext_pri_zero)
    else $error("priority output high under external precedence");

  // ==========================================================================
  // checks: pin routing, synchronisers and readback
  property p_act_unrouted;
    @(posedge clk_in) disable iff (rst_in)
    !acto_ok |=> !local_radio_active_out;
  endproperty
  a_act_unrouted: assert property (p_act_unrouted)
    else $error("activity output driven without its pin code");

  property p_pri_unrouted;
    @(posedge clk_in) disable iff (rst_in)
    !prio_ok |=> !local_priority_out;
  endproperty
  a_pri_unrouted: assert property (p_pri_unrouted)
    else $error("priority output driven without its pin code");

  property p_route_ext;
    @(posedge clk_in) disable iff (rst_in)
    (!in0_en && !in1_en) |=> !radio_inhibit_out;
  endproperty
  a_route_ext: assert property (p_route_ext)
    else $error("unrouted external input inhibited the radio");

  property p_sync_lag0;
    @(posedge clk_in) disable iff (rst_in)
    $rose(ext0_s) |-> $past(ext_activity_in0, 2);
  endproperty
  a_sync_lag0: assert property (p_sync_lag0)
    else $error("first external input bypassed its synchroniser");

  property p_sync_lag1;
    @(posedge clk_in) disable iff (rst_in)
    $rose(ext1_s) |-> $past(ext_activity_in1, 2);
  endproperty
  a_sync_lag1: assert property (p_sync_lag1)
    else $error("second external input bypassed its synchroniser");

  property p_gating_readback;
    @(posedge clk_in) disable iff (rst_in)
    (rd_in && rd_ctrl)
      |=> rdata_out[coex_pkg::CTRL_GATING_BIT] == $past(act_gating_select_r);
  endproperty
  a_gating_readback: assert property (p_gating_readback)
    else $error("gating bit readback wrong");

  property p_owner_readback;
    @(posedge clk_in) disable iff (rst_in)
    (rd_in && rd_prio)
      |=> rdata_out[coex_pkg::PRIO_OWNER_BIT] == $past(priority_owner_select_r);
  endproperty
  a_owner_readback: assert property (p_owner_readback)
    else $error("owner bit readback wrong");
endmodule : coex_signalling

//--- hw/coex_pkg.sv
// Purpose: shared constants for the radio coexistence signalling block
// Assumes: one 50 MHz clock, plain register port with one-cycle read latency
// Notes:   all offsets are byte addresses of 32-bit words
package coex_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] PRIO_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] PINSEL_ADDR = 8'h0c;
  // ==========================================================================
  // field positions
  localparam int CTRL_GATING_BIT  = 0;
  localparam int PRIO_OWNER_BIT   = 0;
  localparam int PINSEL_W         = 6;
  localparam int PINSEL_ACT0_LSB  = 0;
  localparam int PINSEL_ACT1_LSB  = 8;
  localparam int PINSEL_ACTO_LSB  = 16;
  localparam int PINSEL_PRIO_LSB  = 24;
  localparam int STATUS_W         = 5;
  // ==========================================================================
  // reset values: gating off, local precedence
  localparam logic       CTRL_GATING_RST = 1'b0;
  localparam logic       PRIO_OWNER_RST  = 1'b0;
  localparam logic       OWNER_LOCAL     = 1'b0;
  localparam logic       OWNER_EXT       = 1'b1;
  // ==========================================================================
  // pin function codes
  localparam logic [5:0] FUNC_EXT_REQ0 = 6'h30;
  localparam logic [5:0] FUNC_EXT_REQ1 = 6'h31;
  localparam logic [5:0] FUNC_ACT_OUT  = 6'h32;
  localparam logic [5:0] FUNC_PRIO_OUT = 6'h33;
  localparam int         SYNC_STAGES   = 2;
endpackage : coex_pkg

//--- hw/coex_sync.sv
// Purpose: multi-stage level synchroniser
// Assumes: input is asynchronous to clk_in
// Notes:   first stage feeds only the next stage
`timescale 1ns/1ps
module coex_sync #(
  parameter int STAGES = coex_pkg::SYNC_STAGES
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [STAGES-1:0] chain_r;
  // ==========================================================================
  // chain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], d_in};
    end
  end
  assign q_out = chain_r[STAGES-1];
endmodule : coex_sync

//--- hw/coex_envelope.sv
// Purpose: stretches the event envelope until radio activity completes
// Assumes: activity_done_in is high when no radio activity is in flight
// Notes:   level held from envelope rise to envelope-low-and-done
`timescale 1ns/1ps
module coex_envelope (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic event_envelope_in,
  input  wire logic activity_done_in,
  output logic      busy_out
);
  logic busy_r;
  logic busy_nxt;
  // ==========================================================================
  // hold until the envelope has fallen and the last activity is done
  assign busy_nxt = event_envelope_in | (busy_r & ~activity_done_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
  // rises combinationally with the envelope so the output can share its edge
  assign busy_out = event_envelope_in | busy_r;
endmodule : coex_envelope

//--- verification/ext_radio_model.sv
// Purpose: two co-located external radios raising activity requests
// Assumes: requests are levels, changed by the bench just after a clock edge
// Notes:   no release state: each line is a driven level at all times
`timescale 1ns/1ps
module ext_radio_model (
  input  wire logic req0_in,
  input  wire logic req1_in,
  output logic      ext_activity_out0,
  output logic      ext_activity_out1
);
  // ==========================================================================
  // activity announce lines, one per external radio
  assign ext_activity_out0 = req0_in;
  assign ext_activity_out1 = req1_in;
endmodule : ext_radio_model

//--- verification/tb_radio_coexistence_signalling.sv
// Purpose: register and signalling checks of the coexistence block
// Assumes: radio domain powered and clocked before any access
// Notes:   outputs lag envelope by 1 cycle, external inputs by 3
`timescale 1ns/1ps
module tb_radio_coexistence_signalling;
  logic        clk_in, rst_in, wr_in, rd_in, env, done, rq0, rq1;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, rv;
  logic        ext0, ext1, act, pri, inh;
  int          err_count, n_compared;
  // ==========================================================================
  // design and far side
  coex_signalling u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ext_activity_in0(ext0), .ext_activity_in1(ext1), .event_envelope_in(env),
    .activity_done_in(done), .local_radio_active_out(act),
    .local_priority_out(pri), .radio_inhibit_out(inh));
  ext_radio_model u_ext (.req0_in(rq0), .req1_in(rq1),
    .ext_activity_out0(ext0), .ext_activity_out1(ext1));
  always #10 clk_in = ~clk_in;
  // ==========================================================================
  // tasks
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd
  // outputs sampled 1 ns after the n-th edge, where they have settled
  task look(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : look
  task drive(input logic e, input logic d, input logic r0, input logic r1);
    @(posedge clk_in);
    env  <= e;
    done <= d;
    rq0  <= r0;
    rq1  <= r1;
  endtask : drive
  // ==========================================================================
  // sequence
  initial begin
    clk_in = 1'b0; rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0;
    addr_in = 8'h00; wdata_in = 32'h0; env = 1'b0; done = 1'b1;
    rq0 = 1'b0; rq1 = 1'b0; err_count = 0; n_compared = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(coex_pkg::CTRL_ADDR);
    chk(rv, 32'h0);
    rd(coex_pkg::PRIO_ADDR);
    chk(rv, 32'h0);
    rd(8'h10);
    chk(rv, 32'h0);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    look(3);
    chk({act, pri}, 2'b00);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    wr(coex_pkg::PINSEL_ADDR, 32'h33323130);
    rd(coex_pkg::PINSEL_ADDR);
    chk(rv, 32'h33323130);
    // ungated, local owner: rise with envelope, hold until done
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    look(1);
    chk({act, pri}, 2'b11);
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    look(4);
    chk({act, pri}, 2'b11);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    look(3);
    chk({act, pri}, 2'b00);
    // ungated, external owner: priority stays low, external activity inhibits
    wr(coex_pkg::PRIO_ADDR, 32'h1);
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    look(4);
    chk(pri, 1'b0);
    rd(coex_pkg::STATUS_ADDR);
    chk(rv[4:0], 5'b10001);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    // gated, local owner: both rise together
    wr(coex_pkg::PRIO_ADDR, 32'h0);
    wr(coex_pkg::CTRL_ADDR, 32'h1);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    look(1);
    chk({act, pri}, 2'b11);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    look(3);
    // gated, external owner, second radio active: both low, inhibit
    wr(coex_pkg::PRIO_ADDR, 32'h1);
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    look(1);
    chk(inh, 1'b0);
    look(3);
    chk({act, pri, inh}, 3'b001);
    look(5);
    chk({act, pri, inh}, 3'b001);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    look(5);
    chk({act, pri, inh}, 3'b000);
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    test_done();
  end
endmodule : tb_radio_coexistence_signalling
